//--- flash_consts.svh
// Constants of the serial flash operating-feature logic.
// Assumes inclusion by bare name; definitions only.
`ifndef FLASH_CONSTS_SVH
`define FLASH_CONSTS_SVH

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define OP_WREN 8'h06
`define OP_WRDI 8'h04
`define OP_RDSR 8'h05
`define OP_WRSR 8'h01
`define OP_PP   8'h02
`define OP_SE   8'hD8
`define OP_BE   8'hC7

// ----------------------------------------------------------------
// Frame lengths in bytes
// ----------------------------------------------------------------
`define LEN_ONE   12'h001
`define LEN_WRSR  12'h002
`define LEN_SE    12'h004
`define LEN_PPMIN 12'h005
`define LEN_HDR   12'h004

// ----------------------------------------------------------------
// Status register fields and reset values
// ----------------------------------------------------------------
`define SR_BUSY_POS 0
`define SR_WEL_POS  1
`define SR_BP_LSB   2
`define SR_LOCK_POS 7
`define BP_RESET    3'h0
`define LOCK_RESET  1'h0

// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define PAGE_BYTES  256
`define SECTORS     64
`define SECTOR_MSB  23
`define SECTOR_LSB  18

// ----------------------------------------------------------------
// Timing: times in microseconds, clock in MHz
// ----------------------------------------------------------------
`define CLK_MHZ                50
`define PROGRAM_CYCLE_TIME_US  100
`define SECTOR_ERASE_TIME_US   1000
`define BULK_ERASE_TIME_US     2000
`define STATUS_WRITE_TIME_US   50
`define POWERUP_INHIBIT_US     100

`endif

//--- flash_pkg.sv
// Types shared by the serial flash operating-feature logic.
// Assumes flash_consts.svh holds the numbers.
package flash_pkg;

	// Core sequencer states
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_PGM_RD = 3'b001,
		ST_PGM_WR = 3'b010,
		ST_ERASE  = 3'b011,
		ST_WAIT   = 3'b100
	} state_t;

	// Request to the storage array
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic        erase;
		logic        bulk;
		logic [23:0] addr;
		logic [7:0]  wdata;
	} arr_req_t;

	// Status register image
	typedef struct packed {
		logic       status_lock_bit;
		logic [1:0] zero;
		logic [2:0] protect_level;
		logic       write_latch;
		logic       busy_flag;
	} status_t;

endpackage

//--- sync2.sv
// Two-flip-flop level synchroniser, W bits wide.
// Assumes each bit is a slow level or a toggle.
`timescale 1ns/100ps
module sync2 #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] q_nxt;

	// Next values
	always_comb begin
		meta_nxt = rst_n ? d : '0;
		q_nxt    = rst_n ? meta_r : '0;
	end

	// Registers
	always_ff @(posedge clk) begin
		meta_r <= meta_nxt;
		q      <= q_nxt;
	end
endmodule

//--- spi_link.sv
// Serial link front end on the link clock: shift-in, hold, status out.
// Assumes mode 0 or 3 framing; select high clears all link state.
`timescale 1ns/100ps
`include "flash_consts.svh"
module spi_link (
	input  wire logic       sclk,
	input  wire logic       cs_n,
	input  wire logic       hold_n,
	input  wire logic       serial_in,
	input  wire logic [7:0] status_in,
	output logic            byte_tog,
	output logic [7:0]      byte_data,
	output logic            partial,
	output logic            serial_out,
	output logic            serial_out_oe
);
	logic [7:0] stat_m_r, stat_s_r, snap_r, snap_nxt;
	logic [6:0] shift_r, shift_nxt;
	logic [2:0] bit_cnt_r, bit_cnt_nxt;
	logic [7:0] byte_nxt;
	logic       tog_nxt, part_nxt, first_r, first_nxt, rdsr_r, rdsr_nxt;
	logic       hold_q_r, out_nxt, hold_eff;

	// ----------------------------------------------------------------
	// Rising edge: shift in, unless paused
	// ----------------------------------------------------------------
	always_comb begin
		shift_nxt   = shift_r;
		bit_cnt_nxt = bit_cnt_r;
		byte_nxt    = byte_data;
		tog_nxt     = byte_tog;
		first_nxt   = first_r;
		rdsr_nxt    = rdsr_r;
		snap_nxt    = snap_r;
		// A rise always follows a low phase, so the pin level is the hold state
		if (hold_n) begin // RULE_13 RULE_15 RULE_16
			shift_nxt   = {shift_r[5:0], serial_in};
			bit_cnt_nxt = bit_cnt_r + 3'h1;
			if (bit_cnt_r == 3'h7) begin
				byte_nxt  = {shift_r, serial_in};
				tog_nxt   = ~byte_tog;
				first_nxt = 1'b1;
				snap_nxt  = stat_s_r;
				if (!first_r && {shift_r, serial_in} == `OP_RDSR)
					rdsr_nxt = 1'b1;
			end
		end
		part_nxt = (bit_cnt_nxt != 3'h0); // RULE_08
	end

	// Select high clears the link logic
	always_ff @(posedge sclk or posedge cs_n) begin // RULE_18
		if (cs_n) begin
			stat_m_r  <= 8'h00;
			stat_s_r  <= 8'h00;
			shift_r   <= 7'h00;
			bit_cnt_r <= 3'h0;
			byte_data <= 8'h00;
			byte_tog  <= 1'b0;
			partial   <= 1'b0;
			first_r   <= 1'b0;
			rdsr_r    <= 1'b0;
			snap_r    <= 8'h00;
		end else begin
			stat_m_r  <= status_in;
			stat_s_r  <= stat_m_r;
			shift_r   <= shift_nxt;
			bit_cnt_r <= bit_cnt_nxt;
			byte_data <= byte_nxt;
			byte_tog  <= tog_nxt;
			partial   <= part_nxt;
			first_r   <= first_nxt;
			rdsr_r    <= rdsr_nxt;
			snap_r    <= snap_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Falling edge: hold sample and status bit out, MSB first
	// ----------------------------------------------------------------
	always_comb begin
		out_nxt = serial_out;
		if (rdsr_r && hold_n)
			out_nxt = snap_r[~bit_cnt_r];
	end

	always_ff @(negedge sclk or posedge cs_n) begin
		if (cs_n) begin
			hold_q_r   <= 1'b0;
			serial_out <= 1'b0;
		end else begin
			hold_q_r   <= ~hold_n; // RULE_13 RULE_14
			serial_out <= out_nxt;
		end
	end

	// Hold follows the pin while the clock is low, frozen while high
	assign hold_eff = sclk ? hold_q_r : ~hold_n; // RULE_13 RULE_14 RULE_19

	// Drive only while selected and not paused
	assign serial_out_oe = ~cs_n & ~hold_eff & rdsr_r; // RULE_20 RULE_15
endmodule

//--- flash_ctrl.sv
// Operating-feature core of a serial flash: command acceptance, write latch,
// protection, program and erase sequencing, busy and standby state.
// Assumes array answers a read one clk later; link clock unrelated to clk.
//
// Summary of operation
// RULE_01 - A page program takes 1 to 256 bytes, wrapping within one page.
// RULE_02 - Programming only clears bits; new byte is old byte ANDed with data.
// RULE_03 - Host sends write enable, then opcode, three address bytes and data.
// RULE_04 - Modifying commands run only while the write latch is set.
// RULE_05 - Status register shows the busy flag for host polling.
// RULE_06 - Deselected device stays active until an internal cycle ends.
// RULE_07 - After reset a power-up timer blocks all modifying commands.
// RULE_08 - Modifying commands need a clock count that is a multiple of eight.
// RULE_09 - Protect level zero protects nothing, seven protects all 64 sectors.
// RULE_10 - Levels one to six protect top-aligned sectors, doubling each step.
// RULE_11 - Bulk erase runs only when the protect level is zero.
// RULE_12 - While write-protect is low the status register cannot change.
// RULE_13 - Hold starts on hold falling with clock low, else next clock low.
// RULE_14 - Hold ends on hold rising with clock low, else next clock low.
// RULE_15 - During hold output floats and input and clock are ignored.
// RULE_16 - Hold keeps the bit and byte position of the transfer.
// RULE_17 - Hold never stops an internal cycle in progress.
// RULE_18 - Deselect during hold resets the link logic and drops the frame.
// RULE_19 - Host releases hold before selecting again.
// RULE_20 - Serial output is driven only while selected.
// RULE_21 - Host should program a page's bytes in one sequence.
// RULE_22 - Write enable command sets the write latch.
// RULE_23 - Write latch clears at reset and after each modifying operation.
// RULE_24 - A modifying frame ending off a byte boundary is rejected.
// RULE_25 - Busy flag is high from acceptance until the internal cycle ends.
`timescale 1ns/100ps
`include "flash_consts.svh"
module flash_ctrl #(
	parameter int PROG_CYCLES = `PROGRAM_CYCLE_TIME_US * `CLK_MHZ,
	parameter int SE_CYCLES   = `SECTOR_ERASE_TIME_US * `CLK_MHZ,
	parameter int BE_CYCLES   = `BULK_ERASE_TIME_US * `CLK_MHZ,
	parameter int WSR_CYCLES  = `STATUS_WRITE_TIME_US * `CLK_MHZ,
	parameter int PU_CYCLES   = `POWERUP_INHIBIT_US * `CLK_MHZ
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             sclk,
	input  wire logic             cs_n,
	input  wire logic             hold_n,
	input  wire logic             wp_n,
	input  wire logic             serial_in,
	output logic                  serial_out,
	output logic                  serial_out_oe,
	input  wire logic [7:0]       arr_rdata,
	output flash_pkg::arr_req_t   arr_req,
	output logic                  busy_flag,
	output logic                  write_latch,
	output logic [2:0]            protect_level,
	output logic                  status_lock_bit,
	output logic                  standby
);
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	flash_pkg::state_t   state_r, state_nxt;
	flash_pkg::status_t  status_w;
	flash_pkg::arr_req_t req_nxt;
	logic       l_tog, l_part;
	logic [7:0] l_byte;
	logic [3:0] sync_q;
	logic       sel_s, wp_act, tog_s, part_s;
	logic       sel_d_r, tog_seen_r, part_d1_r, part_d2_r;
	logic       ev_d1_r, ev_d2_r, ev_d1_nxt, ev_d2_nxt;
	logic [7:0] dat_d1_r, dat_d2_r;
	logic       frame_start, frame_end, go_w;
	logic [11:0] cnt_r, cnt_nxt;
	logic [7:0]  op_r, op_nxt, wsr_r, wsr_nxt;
	logic [23:0] addr_r, addr_nxt;
	logic [7:0]  pbuf_r [`PAGE_BYTES];
	logic [`PAGE_BYTES-1:0] pvalid_r, pvalid_nxt;
	logic        pb_we;
	logic [7:0]  pb_idx;
	logic [7:0]  idx_r, idx_nxt;
	logic [19:0] timer_r, timer_nxt;
	logic [19:0] pu_r, pu_nxt;
	logic        wel_nxt, lock_nxt, standby_nxt;
	logic [2:0]  bp_nxt;
	logic        ign_r, ign_nxt;

	// Local names for the sequencer states
	localparam flash_pkg::state_t ST_IDLE   = flash_pkg::ST_IDLE;
	localparam flash_pkg::state_t ST_PGM_RD = flash_pkg::ST_PGM_RD;
	localparam flash_pkg::state_t ST_PGM_WR = flash_pkg::ST_PGM_WR;
	localparam flash_pkg::state_t ST_ERASE  = flash_pkg::ST_ERASE;
	localparam flash_pkg::state_t ST_WAIT   = flash_pkg::ST_WAIT;

	// Top-aligned protection by level
	function automatic logic is_prot(input logic [2:0] bp, input logic [5:0] sec);
		logic [6:0] first;
		first = 7'h00;
		if (bp == 3'h0)
			is_prot = 1'b0;
		else if (bp == 3'h7) // RULE_09
			is_prot = 1'b1;
		else begin
			first   = 7'(`SECTORS) - (7'h01 << (bp - 3'h1)); // RULE_10
			is_prot = ({1'b0, sec} >= first);
		end
	endfunction

	// ----------------------------------------------------------------
	// Link front end and crossings
	// ----------------------------------------------------------------
	assign status_w = '{status_lock_bit: status_lock_bit, zero: 2'h0,
		protect_level: protect_level, write_latch: write_latch, busy_flag: busy_flag};

	spi_link u_link (
		.sclk          (sclk),
		.cs_n          (cs_n),
		.hold_n        (hold_n),
		.serial_in     (serial_in),
		.status_in     (status_w), // RULE_05
		.byte_tog      (l_tog),
		.byte_data     (l_byte),
		.partial       (l_part),
		.serial_out    (serial_out),
		.serial_out_oe (serial_out_oe)
	);

	sync2 #(.W(4)) u_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.d     ({~cs_n, ~wp_n, l_tog, l_part}),
		.q     (sync_q)
	);
	assign {sel_s, wp_act, tog_s, part_s} = sync_q;

	assign frame_start = sel_s & ~sel_d_r;
	assign frame_end   = ~sel_s & sel_d_r;

	// Byte events pass two stages so a reset-caused toggle can be flushed
	always_comb begin
		ev_d1_nxt = sel_s & (tog_s != tog_seen_r);
		ev_d2_nxt = ev_d1_r;
		if (frame_end) begin // RULE_18
			ev_d1_nxt = 1'b0;
			ev_d2_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sel_d_r    <= 1'b0;
			tog_seen_r <= 1'b0;
			part_d1_r  <= 1'b0;
			part_d2_r  <= 1'b0;
			ev_d1_r    <= 1'b0;
			ev_d2_r    <= 1'b0;
			dat_d1_r   <= 8'h00;
			dat_d2_r   <= 8'h00;
		end else begin
			sel_d_r    <= sel_s;
			tog_seen_r <= tog_s;
			part_d1_r  <= part_s;
			part_d2_r  <= part_d1_r;
			ev_d1_r    <= ev_d1_nxt;
			ev_d2_r    <= ev_d2_nxt;
			dat_d1_r   <= l_byte;
			dat_d2_r   <= dat_d1_r;
		end
	end

	// ----------------------------------------------------------------
	// Frame collection: opcode, address, status byte, page data
	// ----------------------------------------------------------------
	always_comb begin
		cnt_nxt    = cnt_r;
		op_nxt     = op_r;
		addr_nxt   = addr_r;
		wsr_nxt    = wsr_r;
		pvalid_nxt = pvalid_r;
		pb_we      = 1'b0;
		pb_idx     = 8'(addr_r[7:0] + cnt_r[7:0] - 8'h04); // RULE_01
		ign_nxt    = ign_r;
		// A frame opened during an internal cycle must not touch its operands
		if (frame_start) begin
			ign_nxt = (state_r != ST_IDLE); // RULE_17
			if (state_r == ST_IDLE) begin
				cnt_nxt    = 12'h000;
				pvalid_nxt = '0;
			end
		end else if (ev_d2_r && !ign_r) begin
			if (cnt_r != 12'hFFF)
				cnt_nxt = cnt_r + 12'h001;
			case (cnt_r)
				12'h000: op_nxt = dat_d2_r;
				12'h001: begin
					addr_nxt[23:16] = dat_d2_r;
					wsr_nxt         = dat_d2_r;
				end
				12'h002: addr_nxt[15:8] = dat_d2_r;
				12'h003: addr_nxt[7:0]  = dat_d2_r;
				default: begin
					if (op_r == `OP_PP) begin // RULE_03
						pb_we              = 1'b1;
						pvalid_nxt[pb_idx] = 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_r    <= 12'h000;
			op_r     <= 8'h00;
			addr_r   <= 24'h000000;
			wsr_r    <= 8'h00;
			pvalid_r <= '0;
			ign_r    <= 1'b0;
		end else begin
			cnt_r    <= cnt_nxt;
			op_r     <= op_nxt;
			addr_r   <= addr_nxt;
			wsr_r    <= wsr_nxt;
			pvalid_r <= pvalid_nxt;
			ign_r    <= ign_nxt;
		end
	end

	// Page buffer storage
	always_ff @(posedge clk) begin
		if (pb_we)
			pbuf_r[pb_idx] <= dat_d2_r;
	end

	// ----------------------------------------------------------------
	// Acceptance and internal cycle sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		timer_nxt = (timer_r != 20'h00000) ? timer_r - 20'h00001 : timer_r;
		pu_nxt    = (pu_r != 20'h00000) ? pu_r - 20'h00001 : pu_r;
		idx_nxt   = idx_r;
		wel_nxt   = write_latch;
		bp_nxt    = protect_level;
		lock_nxt  = status_lock_bit;
		req_nxt   = '0;
		req_nxt.addr = arr_req.addr;
		go_w      = 1'b0;
		case (state_r)
			ST_IDLE: begin
				// Byte boundary and power-up checks gate everything; latch checks gate only modifying commands
				if (frame_end && !ign_r && !part_d1_r && !part_d2_r // RULE_08 RULE_24
					&& pu_r == 20'h00000) begin // RULE_07
					case (op_r)
						`OP_WREN: if (cnt_r == `LEN_ONE) wel_nxt = 1'b1; // RULE_22
						`OP_WRDI: if (cnt_r == `LEN_ONE) wel_nxt = 1'b0; // RULE_23
						`OP_WRSR: if (cnt_r == `LEN_WRSR && write_latch && !wp_act) begin
							go_w      = 1'b1; // RULE_04 RULE_12
							timer_nxt = 20'(WSR_CYCLES);
							state_nxt = ST_WAIT;
						end
						`OP_PP: if (cnt_r >= `LEN_PPMIN && write_latch
							&& !is_prot(protect_level, addr_r[`SECTOR_MSB:`SECTOR_LSB])) begin
							go_w      = 1'b1; // RULE_04 RULE_09 RULE_10
							timer_nxt = 20'(PROG_CYCLES);
							idx_nxt   = 8'h00;
							state_nxt = ST_PGM_RD;
						end
						`OP_SE: if (cnt_r == `LEN_SE && write_latch
							&& !is_prot(protect_level, addr_r[`SECTOR_MSB:`SECTOR_LSB])) begin
							go_w      = 1'b1; // RULE_04 RULE_09 RULE_10
							timer_nxt = 20'(SE_CYCLES);
							state_nxt = ST_ERASE;
						end
						`OP_BE: if (cnt_r == `LEN_ONE && write_latch
							&& protect_level == 3'h0) begin
							go_w      = 1'b1; // RULE_04 RULE_11
							timer_nxt = 20'(BE_CYCLES);
							state_nxt = ST_ERASE;
						end
						default: ;
					endcase
				end
			end
			ST_PGM_RD: begin
				// Read the old byte only where data arrived
				req_nxt.addr = {addr_r[23:8], idx_r};
				if (pvalid_r[idx_r]) begin
					req_nxt.rd = 1'b1;
					state_nxt  = ST_PGM_WR;
				end else if (idx_r == 8'hFF)
					state_nxt = ST_WAIT;
				else
					idx_nxt = idx_r + 8'h01;
			end
			ST_PGM_WR: begin
				req_nxt.wr    = 1'b1;
				req_nxt.wdata = arr_rdata & pbuf_r[idx_r]; // RULE_02
				idx_nxt       = idx_r + 8'h01;
				state_nxt     = (idx_r == 8'hFF) ? ST_WAIT : ST_PGM_RD;
			end
			ST_ERASE: begin
				req_nxt.erase = 1'b1;
				req_nxt.bulk  = (op_r == `OP_BE);
				req_nxt.addr  = {addr_r[23:18], 18'h00000};
				state_nxt     = ST_WAIT;
			end
			ST_WAIT: begin
				// Cycle runs on regardless of hold or select
				if (timer_r == 20'h00000) begin // RULE_17
					if (op_r == `OP_WRSR && !wp_act) begin // RULE_12
						bp_nxt   = wsr_r[`SR_BP_LSB+2:`SR_BP_LSB];
						lock_nxt = wsr_r[`SR_LOCK_POS];
					end
					wel_nxt   = 1'b0; // RULE_23
					state_nxt = ST_IDLE;
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
		standby_nxt = ~sel_s & (state_nxt == ST_IDLE); // RULE_06
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_r         <= ST_IDLE;
			timer_r         <= 20'h00000;
			pu_r            <= 20'(PU_CYCLES);
			idx_r           <= 8'h00;
			write_latch     <= 1'b0;
			protect_level   <= `BP_RESET;
			status_lock_bit <= `LOCK_RESET;
			arr_req         <= '0;
			busy_flag       <= 1'b0;
			standby         <= 1'b0;
		end else begin
			state_r         <= state_nxt;
			timer_r         <= timer_nxt;
			pu_r            <= pu_nxt;
			idx_r           <= idx_nxt;
			write_latch     <= wel_nxt;
			protect_level   <= bp_nxt;
			status_lock_bit <= lock_nxt;
			arr_req         <= req_nxt;
			busy_flag       <= (state_nxt != ST_IDLE); // RULE_25
			standby         <= standby_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_go_needs_latch;
		@(posedge clk) disable iff (!rst_n) go_w |-> write_latch ##1 busy_flag;
	endproperty
	a_go_needs_latch: assert property (p_go_needs_latch) else $error("cycle without latch"); // RULE_04

	property p_latch_clear;
		@(posedge clk) disable iff (!rst_n) $fell(busy_flag) |-> !write_latch;
	endproperty
	a_latch_clear: assert property (p_latch_clear) else $error("latch kept after cycle"); // RULE_23

	property p_bulk_level;
		@(posedge clk) disable iff (!rst_n) arr_req.erase && arr_req.bulk |-> protect_level == 3'h0;
	endproperty
	a_bulk_level: assert property (p_bulk_level) else $error("bulk erase while protected"); // RULE_11

	property p_erase_prot;
		@(posedge clk) disable iff (!rst_n)
			arr_req.erase && !arr_req.bulk |-> !is_prot(protect_level, arr_req.addr[23:18]);
	endproperty
	a_erase_prot: assert property (p_erase_prot) else $error("protected sector erased"); // RULE_10

	property p_clear_only;
		@(posedge clk) disable iff (!rst_n) arr_req.wr |-> (arr_req.wdata & ~$past(arr_rdata)) == 8'h00;
	endproperty
	a_clear_only: assert property (p_clear_only) else $error("program set a bit"); // RULE_02

	property p_powerup;
		@(posedge clk) disable iff (!rst_n) pu_r != 20'h00000 |=> !$rose(write_latch) && !$rose(busy_flag);
	endproperty
	a_powerup: assert property (p_powerup) else $error("change during power-up"); // RULE_07

	property p_wp_freeze;
		@(posedge clk) disable iff (!rst_n) wp_act |=> $stable(protect_level) && $stable(status_lock_bit);
	endproperty
	a_wp_freeze: assert property (p_wp_freeze) else $error("status changed under protect"); // RULE_12

	property p_partial_reject;
		@(posedge clk) disable iff (!rst_n) frame_end && part_d2_r |=> !busy_flag && $stable(write_latch);
	endproperty
	a_partial_reject: assert property (p_partial_reject) else $error("partial frame ran"); // RULE_24

	property p_standby;
		@(posedge clk) disable iff (!rst_n) busy_flag || $past(sel_s) |-> !standby;
	endproperty
	a_standby: assert property (p_standby) else $error("standby while active"); // RULE_06

	cover property (@(posedge clk) disable iff (!rst_n) arr_req.wr);
	cover property (@(posedge clk) disable iff (!rst_n) arr_req.erase && !arr_req.bulk);
	cover property (@(posedge clk) disable iff (!rst_n) arr_req.erase && arr_req.bulk);
	cover property (@(posedge clk) disable iff (!rst_n) go_w && op_r == `OP_WRSR);
endmodule

//--- arr_model.sv
// Behavioural storage array answering the flash core's requests.
// Assumes registered request pulses on clk; read data while the pulse stands.
`timescale 1ns/100ps
module arr_model (
	input  wire  logic                clk,
	input  wire  flash_pkg::arr_req_t arr_req,
	output logic [7:0]                arr_rdata
);
	logic [7:0] mem [int];
	int         q   [$];

	// Unwritten or erased bytes read all ones
	function automatic logic [7:0] rd(input int a);
		return mem.exists(a) ? mem[a] : 8'hFF;
	endfunction

	initial arr_rdata = 8'h5A;

	// Reads answer in the cycle the pulse stands; otherwise a changing pattern
	always @(posedge clk) begin
		if (arr_req.wr) mem[arr_req.addr] = arr_req.wdata;
		if (arr_req.erase && arr_req.bulk) mem.delete();
		else if (arr_req.erase) begin
			q.delete();
			foreach (mem[a]) if (a[23:18] == arr_req.addr[23:18]) q.push_back(a);
			foreach (q[i]) mem.delete(q[i]);
		end
		#1 arr_rdata = arr_req.rd ? rd(arr_req.addr) : ~arr_rdata;
	end
endmodule

//--- tb.sv
// Self-checking bench: link host tasks, array partner, reference values.
// Assumes the design files and arr_model.sv are compiled first.
`timescale 1ns/100ps
module tb;
	localparam int         PU = 100;
	localparam logic [7:0] RD = 8'h05;
	logic       clk = 1'b0, rst_n = 1'b0, sclk = 1'b0, cs_n = 1'b1, hold_n = 1'b1;
	logic       wp_n = 1'b1, serial_in = 1'b0;
	logic       serial_out, serial_out_oe, busy_flag, write_latch, status_lock_bit, standby;
	logic [2:0] protect_level;
	logic [7:0] arr_rdata, sv, d1, d2, e1;
	int         errors = 0, checks_done = 0, cyc = 0, a1, b;
	flash_pkg::arr_req_t arr_req;

	flash_ctrl #(.PROG_CYCLES(60), .SE_CYCLES(60), .BE_CYCLES(80), .WSR_CYCLES(40),
		.PU_CYCLES(PU)) u_flash_ctrl (.clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
		.hold_n(hold_n), .wp_n(wp_n), .serial_in(serial_in), .serial_out(serial_out),
		.serial_out_oe(serial_out_oe), .arr_rdata(arr_rdata), .arr_req(arr_req),
		.busy_flag(busy_flag), .write_latch(write_latch), .protect_level(protect_level),
		.status_lock_bit(status_lock_bit), .standby(standby));
	arr_model u_arr_model (.clk(clk), .arr_req(arr_req), .arr_rdata(arr_rdata));

	always #10 clk = ~clk;

	// ------------------------------------------------------------
	// Checking and link tasks
	// ------------------------------------------------------------
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		checks_done++;
		if (s !== e) begin
			errors++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic conclude();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	// One link clock, data set while low, output sampled at rise
	task automatic pulse(input logic d, output logic q);
		serial_in = d;
		#80 sclk = 1'b1;
		q = serial_out;
		#80 sclk = 1'b0;
	endtask

	// Framed command; optional hold at bit hb, deselected in hold if drop
	task automatic xfer(input logic [7:0] by [$], input int extra = 0, input int hb = -1,
		input bit drop = 0);
		logic q;
		cs_n = 1'b0;
		#100;
		for (int i = 0; i < by.size() * 8 + extra; i++) begin
			if (i == hb) begin
				hold_n = 1'b0;
				repeat (3) pulse(~serial_in, q);
				chk("oe_hold", 0, serial_out_oe);
				if (drop) cs_n = 1'b1;
				#200 hold_n = 1'b1;
				#100;
			end
			if (cs_n) break;
			pulse(i / 8 < by.size() ? by[i / 8][7 - i % 8] : 1'b0, q);
		end
		#100 cs_n = 1'b1;
		#400;
	endtask

	task automatic rdsr(output logic [7:0] v);
		logic q;
		cs_n = 1'b0;
		#100;
		for (int i = 0; i < 16; i++) begin
			if (i == 12) begin
				hold_n = 1'b0;
				#40 chk("oe_hold_rd", 0, serial_out_oe);
				hold_n = 1'b1;
				#40;
			end
			pulse(i < 8 ? RD[7 - i] : 1'b0, q);
			if (i >= 8) v[15 - i] = q;
		end
		chk("oe_sel", 1, serial_out_oe);
		#100 cs_n = 1'b1;
		#400;
		chk("oe_desel", 0, serial_out_oe);
	endtask

	task automatic wait_idle();
		for (int i = 0; i < 3000 && busy_flag !== 1'b0; i++) @(posedge clk);
		#2;
	endtask

	task automatic wrsr(input logic [2:0] l);
		xfer('{8'h06});
		xfer('{8'h01, {3'b000, l, 2'b00}});
		wait_idle();
	endtask

	// Sector erase (s >= 0) or bulk erase, accepted only when ok
	task automatic op(input int s, input bit ok);
		logic [7:0] sb;
		sb = {s[5:0], 2'b00};
		xfer('{8'h06});
		if (s < 0) xfer('{8'hC7});
		else xfer('{8'hD8, sb, 8'h00, 8'h00});
		chk("erase_busy", ok, busy_flag);
		wait_idle();
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			errors++;
			conclude();
		end
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(11518));
		repeat (4) @(posedge clk);
		#2 rst_n = 1'b1;
		xfer('{8'h06});
		chk("latch_pu", 0, write_latch);
		repeat (PU) @(posedge clk);
		xfer('{8'h06});
		chk("latch_set", 1, write_latch);
		rdsr(sv);
		chk("status", 8'h02, sv);
		xfer('{8'h04});
		chk("latch_clr", 0, write_latch);
		a1 = $urandom % 256;
		d1 = $urandom;
		d2 = $urandom;
		xfer('{8'h02, 8'h00, 8'h10, a1[7:0], d1});
		chk("busy_nolatch", 0, busy_flag);
		xfer('{8'h06});
		xfer('{8'h02, 8'h00, 8'h10, a1[7:0], d1}, 3);
		chk("busy_partial", 0, busy_flag);
		xfer('{8'h02, 8'h00, 8'h10, a1[7:0], d1, d2});
		chk("busy_pp", 1, busy_flag);
		chk("standby_busy", 0, standby);
		wait_idle();
		chk("standby_idle", 1, standby);
		chk("latch_done", 0, write_latch);
		chk("wrap", d2, u_arr_model.rd(32'h1000 + (a1 + 1) % 256));
		e1 = d1 & d2;
		xfer('{8'h06});
		xfer('{8'h02, 8'h00, 8'h10, a1[7:0], d2}, 0, 20);
		cs_n = 1'b0;
		#100 hold_n = 1'b0;
		repeat (20) @(posedge clk);
		chk("busy_hold", 1, busy_flag);
		hold_n = 1'b1;
		#100 cs_n = 1'b1;
		wait_idle();
		chk("and_prog", e1, u_arr_model.rd(32'h1000 + a1));
		xfer('{8'h06});
		xfer('{8'h02, 8'h00, 8'h10, a1[7:0], 8'h00}, 0, 12, 1);
		chk("busy_drop", 0, busy_flag);
		for (int lvl = 7; lvl >= 0; lvl--) begin
			b = lvl == 7 ? 0 : (lvl == 0 ? 64 : 64 - (1 << (lvl - 1)));
			wrsr(lvl[2:0]);
			chk("level", lvl, protect_level);
			op(63, b > 63);
			if (b > 0) op(b - 1, 1);
			op(-1, lvl == 0);
		end
		chk("erased", 8'hFF, u_arr_model.rd(32'h1000 + a1));
		@(posedge clk);
		#2 wp_n = 1'b0;
		wrsr(3'h5);
		chk("level_wp", 0, protect_level);
		wp_n = 1'b1;
		conclude();
	end
endmodule
